// >>> rtl/rcsp_pkg.sv
// Shared constants and types for the radio configuration serial port.
// Assumes a core clock of 20 MHz and a host-driven serial clock.
package rcsp_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [BYTE_W-2:0] SHIFT_RST = 7'h00;

	// ----------------------------------------------------------------
	// Control modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PIN_CONTROL_MODE = 2'b01,
		SERIAL_CONTROL_MODE = 2'b10
	} rcsp_mode_e;

endpackage

// >>> rtl/rcsp_xfer_if.sv
// Signals passed between core logic and the serial-clock shifter.
// Toggles and levels cross by synchronisers; bytes are held stable.
`timescale 1ns/1ps

interface rcsp_xfer_if;
	import rcsp_pkg::*;

	logic rd_req_tgl;
	logic [BYTE_W-1:0] rd_byte;
	logic rd_ack_tgl;
	logic wr_tgl;
	logic [BYTE_W-1:0] wr_byte;
	logic serial_mode;

	modport core (
		output rd_req_tgl,
		output rd_byte,
		output serial_mode,
		input rd_ack_tgl,
		input wr_tgl,
		input wr_byte
	);

	modport link (
		input rd_req_tgl,
		input rd_byte,
		input serial_mode,
		output rd_ack_tgl,
		output wr_tgl,
		output wr_byte
	);

endinterface

// >>> rtl/rcsp_link.sv
// Shifter on the serial clock: collects write bytes, shifts out reads.
// Assumes port enable and data are set up by the host before each edge.
`timescale 1ns/1ps

module rcsp_link
(
	input wire logic ser_clk,
	input wire logic rst_n,
	input wire logic port_en,
	input wire logic din,
	output logic dout_r,
	output logic oe_r,
	rcsp_xfer_if.link xf
);
	import rcsp_pkg::*;

	logic clr_n;
	logic [CNT_W-1:0] bit_cnt_r;
	logic [BYTE_W-2:0] sh_in_r;
	logic [BYTE_W-2:0] rd_sh_r;
	logic [CNT_W-1:0] rd_left_r;
	logic rd_act_r;
	logic rd_seen_r;
	logic wr_tgl_r;
	logic [BYTE_W-1:0] wr_byte_r;
	logic req_m, req_s, mode_m, mode_s;
	logic rd_start, rd_end, wr_go;

	// ----------------------------------------------------------------
	// Gating and synchronisers
	// ----------------------------------------------------------------
	// Shifter held clear while the port is disabled
	assign clr_n = rst_n & port_en;

	// Request toggle and mode level into the serial clock domain
	always_ff @(posedge ser_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			mode_m <= 1'b0;
			mode_s <= 1'b0;
		end
		else
		begin
			req_m <= xf.rd_req_tgl;
			req_s <= req_m;
			mode_m <= xf.serial_mode;
			mode_s <= mode_m;
		end
	end

	// Read starts only at a byte boundary; write shifts when no read starts or runs, and on the edge a read ends
	assign rd_start = port_en && !rd_act_r && bit_cnt_r == CNT_ZERO
		&& (req_s != rd_seen_r);
	assign rd_end = rd_act_r && rd_left_r == CNT_ZERO;
	assign wr_go = !rd_start && (!rd_act_r || rd_end);

	// ----------------------------------------------------------------
	// Write path
	// ----------------------------------------------------------------
	// Bits enter MSB first on rising edges, byte handed over on the 8th
	always_ff @(posedge ser_clk or negedge clr_n)
	begin
		if (!clr_n)
		begin
			bit_cnt_r <= CNT_ZERO;
			sh_in_r <= SHIFT_RST;
		end
		else if (wr_go)
		begin
			sh_in_r <= {sh_in_r[BYTE_W-3:0], din};
			bit_cnt_r <= bit_cnt_r + CNT_ONE;
		end
	end

	// Handover toggle and held byte; only moved while enabled
	always_ff @(posedge ser_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_tgl_r <= 1'b0;
			wr_byte_r <= BYTE_RST;
		end
		else if (port_en && wr_go && bit_cnt_r == LAST_BIT)
		begin
			wr_byte_r <= {sh_in_r, din};
			wr_tgl_r <= !wr_tgl_r;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Acknowledge toggle follows the request when shifting begins
	always_ff @(posedge ser_clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_seen_r <= 1'b0;
		else if (rd_start)
			rd_seen_r <= req_s;
	end

	// Next bit driven on each rising edge, driver on only while reading
	always_ff @(posedge ser_clk or negedge clr_n)
	begin
		if (!clr_n)
		begin
			rd_act_r <= 1'b0;
			rd_left_r <= CNT_ZERO;
			rd_sh_r <= SHIFT_RST;
			dout_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else if (rd_start)
		begin
			rd_act_r <= 1'b1;
			rd_left_r <= LAST_BIT;
			dout_r <= xf.rd_byte[BYTE_W-1];
			rd_sh_r <= xf.rd_byte[BYTE_W-2:0];
			oe_r <= mode_s;
		end
		else if (rd_end)
		begin
			rd_act_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else if (rd_act_r)
		begin
			dout_r <= rd_sh_r[BYTE_W-2];
			rd_sh_r <= {rd_sh_r[BYTE_W-3:0], 1'b0};
			rd_left_r <= rd_left_r - CNT_ONE;
		end
	end

	assign xf.rd_ack_tgl = rd_seen_r;
	assign xf.wr_tgl = wr_tgl_r;
	assign xf.wr_byte = wr_byte_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_oe_only_read;
		@(posedge ser_clk) disable iff (!clr_n)
		oe_r |-> rd_act_r && mode_s;
	endproperty
	a_oe_only_read: assert property (p_oe_only_read)
		else $error("data driver on outside a read");

	property p_read_len;
		@(posedge ser_clk) disable iff (!clr_n)
		rd_start && mode_s |=> oe_r [*8] ##1 !oe_r;
	endproperty
	a_read_len: assert property (p_read_len)
		else $error("read did not drive eight bits");

	property p_shift_bit;
		@(posedge ser_clk) disable iff (!clr_n)
		rd_act_r && !rd_end && !rd_start |=> dout_r == $past(rd_sh_r[BYTE_W-2]);
	endproperty
	a_shift_bit: assert property (p_shift_bit)
		else $error("read bit out of order");

	property p_capture;
		@(posedge ser_clk) disable iff (!clr_n)
		wr_go && bit_cnt_r == LAST_BIT |=> wr_byte_r == $past({sh_in_r, din})
			&& wr_tgl_r != $past(wr_tgl_r);
	endproperty
	a_capture: assert property (p_capture)
		else $error("byte not handed over on eighth bit");

	property p_idle_disabled;
		@(posedge ser_clk) disable iff (!rst_n)
		!port_en |=> $stable(wr_tgl_r) && $stable(rd_seen_r);
	endproperty
	a_idle_disabled: assert property (p_idle_disabled)
		else $error("shift while port disabled");

endmodule

// >>> rtl/rcsp_top.sv
// Radio configuration serial port, core side and pin interface.
// Assumes host drives port enable, serial clock and data line levels.
//
// What this block does
// - In serial mode the data line is received on writes and driven on reads.
// - Bits shift only while port enable is 1, which the host raises first.
// - Every eight received bits are moved into the control register.
// - A write bit is captured on each rising serial clock edge.
// - A read bit is put on the line at each rising serial clock edge.
// - With port enable at 0 serial clock pulses are ignored.
// - Start in pin control mode, switch for good to serial on first enable.
// - Raising port enable wakes the radio from sleep.
// - Write bits arrive a byte at a time, leftmost bit first.
`timescale 1ns/1ps

module rcsp_top
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PORT_EN,
	input wire logic SER_CLOCK_LINE,
	input wire logic SER_DATA_LINE_IN,
	output logic SER_DATA_LINE_OUT,
	output logic SER_DATA_LINE_OE,
	input wire logic READ_REQ,
	input wire logic [rcsp_pkg::BYTE_W-1:0] READ_BYTE,
	input wire logic SLEEP_REQ,
	output logic [rcsp_pkg::BYTE_W-1:0] CTRL_REG,
	output logic WR_STROBE,
	output logic SERIAL_MODE,
	output logic AWAKE,
	output logic READ_BUSY,
	output logic READ_TAKEN
);
	import rcsp_pkg::*;

	rcsp_xfer_if xf ();

	rcsp_mode_e mode_r;
	logic en_m, en_s;
	logic wr_m, wr_s, wr_q;
	logic ack_m, ack_s, ack_q;
	logic req_tgl_r;
	logic [BYTE_W-1:0] rd_byte_r;
	logic [BYTE_W-1:0] ctrl_r;
	logic wr_strobe_r, awake_r, busy_r, taken_r;
	logic busy, wr_evt;

	// ----------------------------------------------------------------
	// Serial clock domain shifter
	// ----------------------------------------------------------------
	rcsp_link u_link
	(
		.ser_clk(SER_CLOCK_LINE),
		.rst_n(RST_N),
		.port_en(PORT_EN),
		.din(SER_DATA_LINE_IN),
		.dout_r(SER_DATA_LINE_OUT),
		.oe_r(SER_DATA_LINE_OE),
		.xf(xf.link)
	);

	// ----------------------------------------------------------------
	// Synchronisers into the core clock
	// ----------------------------------------------------------------
	// Enable pin, write toggle and read acknowledge toggle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			en_m <= 1'b0;
			en_s <= 1'b0;
			wr_m <= 1'b0;
			wr_s <= 1'b0;
			wr_q <= 1'b0;
			ack_m <= 1'b0;
			ack_s <= 1'b0;
			ack_q <= 1'b0;
		end
		else
		begin
			en_m <= PORT_EN;
			en_s <= en_m;
			wr_m <= xf.wr_tgl;
			wr_s <= wr_m;
			wr_q <= wr_s;
			ack_m <= xf.rd_ack_tgl;
			ack_s <= ack_m;
			ack_q <= ack_s;
		end
	end

	assign wr_evt = wr_s ^ wr_q;
	assign busy = req_tgl_r ^ ack_s;

	// ----------------------------------------------------------------
	// Mode and power state
	// ----------------------------------------------------------------
	// Pin control until the first enable, then serial for good
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			mode_r <= PIN_CONTROL_MODE;
		else if (en_s)
			mode_r <= SERIAL_CONTROL_MODE;
	end

	// Enable wakes; core sleep request only while enable is low
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			awake_r <= 1'b0;
		else if (en_s)
			awake_r <= 1'b1;
		else if (SLEEP_REQ)
			awake_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Control register load
	// ----------------------------------------------------------------
	// Received byte transferred on each handover toggle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_r <= CTRL_RST;
			wr_strobe_r <= 1'b0;
		end
		else
		begin
			wr_strobe_r <= wr_evt;
			if (wr_evt)
				ctrl_r <= xf.wr_byte;
		end
	end

	// ----------------------------------------------------------------
	// Read request handshake
	// ----------------------------------------------------------------
	// Byte held stable until the shifter takes it; requests while busy dropped
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			req_tgl_r <= 1'b0;
			rd_byte_r <= BYTE_RST;
			busy_r <= 1'b0;
			taken_r <= 1'b0;
		end
		else
		begin
			taken_r <= ack_s ^ ack_q;
			busy_r <= busy || READ_REQ;
			if (READ_REQ && !busy)
			begin
				req_tgl_r <= !req_tgl_r;
				rd_byte_r <= READ_BYTE;
			end
		end
	end

	assign xf.rd_req_tgl = req_tgl_r;
	assign xf.rd_byte = rd_byte_r;
	assign xf.serial_mode = (mode_r == SERIAL_CONTROL_MODE);

	assign CTRL_REG = ctrl_r;
	assign WR_STROBE = wr_strobe_r;
	assign SERIAL_MODE = mode_r[1];
	assign AWAKE = awake_r;
	assign READ_BUSY = busy_r;
	assign READ_TAKEN = taken_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_mode_sticky;
		@(posedge CLK) disable iff (!RST_N)
		mode_r == SERIAL_CONTROL_MODE |=> mode_r == SERIAL_CONTROL_MODE;
	endproperty
	a_mode_sticky: assert property (p_mode_sticky)
		else $error("serial mode left");

	property p_mode_set;
		@(posedge CLK) disable iff (!RST_N)
		$rose(en_s) |=> mode_r == SERIAL_CONTROL_MODE && awake_r;
	endproperty
	a_mode_set: assert property (p_mode_set)
		else $error("enable did not select serial mode");

	property p_wake;
		@(posedge CLK) disable iff (!RST_N)
		en_s |=> awake_r;
	endproperty
	a_wake: assert property (p_wake)
		else $error("enable did not wake");

	property p_ctrl_load;
		@(posedge CLK) disable iff (!RST_N)
		wr_evt |=> wr_strobe_r && ctrl_r == $past(xf.wr_byte) ##1 !wr_strobe_r;
	endproperty
	a_ctrl_load: assert property (p_ctrl_load)
		else $error("control register not loaded");

	property p_ctrl_hold;
		@(posedge CLK) disable iff (!RST_N)
		!wr_strobe_r |-> ctrl_r == $past(ctrl_r);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold)
		else $error("control register changed without a byte");

endmodule

// >>> test/rcsp_host_model.sv
// Host model: drives port enable, serial clock and its half of the data wire.
// Assumes the device output and enable follow its serial clock rises.
`timescale 1ns/1ps

module rcsp_host_model
(
	output logic ser_clk,
	output logic port_en,
	input wire logic dev_out,
	input wire logic dev_oe,
	output logic line_lvl
);
	logic host_oe = 1'b0;
	logic host_bit = 1'b0;
	logic idle_bit = 1'b0;
	int clashes = 0;

	// Clock stands still between frames
	initial
	begin
		ser_clk = 1'b0;
		port_en = 1'b0;
	end

	// Released wire wanders so a stale bit never reads as valid
	always #16 idle_bit = ~idle_bit;
	assign line_lvl = dev_oe ? dev_out : (host_oe ? host_bit : idle_bit);

	// Both drivers on at once is a fight on the wire
	always @(posedge dev_oe or posedge host_oe)
		if (dev_oe && host_oe)
			clashes++;

	// Enable level, changed only while the clock is still
	task automatic set_en(input logic lvl);
		port_en = lvl;
		#40;
	endtask

	// One bit per pulse, leftmost first; reads sampled on the fall
	task automatic shift(input logic [7:0] wb, input int nbits, input logic rd,
		output logic [7:0] rb);
		rb = 8'h00;
		for (int i = 0; i < nbits; i++)
		begin
			host_oe = ~rd;
			host_bit = wb[7-i];
			#16 ser_clk = 1'b1;
			#16 ser_clk = 1'b0;
			rb = {rb[6:0], line_lvl};
		end
		host_oe = 1'b0;
	endtask
endmodule

// >>> test/rcsp_top_test.sv
// Bench for the radio configuration serial port against a host model.
// Assumes the host model's tasks are called through its instance.
`timescale 1ns/1ps

module rcsp_top_test;
	import rcsp_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic read_req = 1'b0;
	logic [BYTE_W-1:0] read_byte = 8'h00;
	logic sleep_req = 1'b0;
	logic ser_clk, port_en, line_lvl, d_out, d_oe;
	logic [BYTE_W-1:0] ctrl_reg, rb;
	logic wr_strobe, serial_mode, awake, read_busy, read_taken;
	int mismatches = 0;
	int n_checks = 0;
	int strobes = 0;
	int taken = 0;

	// ----------------------------------------------------------------
	// Clock, design and host
	// ----------------------------------------------------------------
	always #25 clk = ~clk;

	rcsp_top i_rcsp_top
	(
		.CLK(clk),
		.RST_N(rst_n),
		.PORT_EN(port_en),
		.SER_CLOCK_LINE(ser_clk),
		.SER_DATA_LINE_IN(line_lvl),
		.SER_DATA_LINE_OUT(d_out),
		.SER_DATA_LINE_OE(d_oe),
		.READ_REQ(read_req),
		.READ_BYTE(read_byte),
		.SLEEP_REQ(sleep_req),
		.CTRL_REG(ctrl_reg),
		.WR_STROBE(wr_strobe),
		.SERIAL_MODE(serial_mode),
		.AWAKE(awake),
		.READ_BUSY(read_busy),
		.READ_TAKEN(read_taken)
	);

	rcsp_host_model i_rcsp_host_model
	(
		.ser_clk(ser_clk),
		.port_en(port_en),
		.dev_out(d_out),
		.dev_oe(d_oe),
		.line_lvl(line_lvl)
	);

	// Pulses counted mid-cycle, where they are settled
	always @(negedge clk)
	begin
		if (wr_strobe === 1'b1)
			strobes++;
		if (read_taken === 1'b1)
			taken++;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bounded wait for a given count of write strobes
	task automatic wait_strobes(input int n);
		for (int i = 0; i < 40 && strobes < n; i++)
			@(negedge clk);
		if (strobes < n)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, strobes, n);
			final_report();
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_ignored();
		i_rcsp_host_model.shift(8'hff, 8, 1'b0, rb);
		repeat (8) @(negedge clk);
		chk(8'(strobes), 8'h00);
		chk(8'(serial_mode), 8'h00);
	endtask

	task automatic t_write();
		i_rcsp_host_model.set_en(1'b1);
		i_rcsp_host_model.shift(8'ha5, 8, 1'b0, rb);
		wait_strobes(1);
		chk(ctrl_reg, 8'ha5);
		i_rcsp_host_model.shift(8'h3c, 8, 1'b0, rb);
		wait_strobes(2);
		chk(ctrl_reg, 8'h3c);
		chk(8'(serial_mode), 8'h01);
		chk(8'(awake), 8'h01);
		i_rcsp_host_model.set_en(1'b0);
		repeat (4) @(negedge clk);
		chk(8'(serial_mode), 8'h01);
	endtask

	// Enable dropped mid-byte, then clocks while disabled
	task automatic t_partial();
		i_rcsp_host_model.set_en(1'b1);
		i_rcsp_host_model.shift(8'hff, 5, 1'b0, rb);
		i_rcsp_host_model.set_en(1'b0);
		i_rcsp_host_model.shift(8'hff, 8, 1'b0, rb);
		i_rcsp_host_model.set_en(1'b1);
		i_rcsp_host_model.shift(8'h96, 8, 1'b0, rb);
		wait_strobes(3);
		repeat (8) @(negedge clk);
		chk(ctrl_reg, 8'h96);
		chk(8'(strobes), 8'h03);
		i_rcsp_host_model.set_en(1'b0);
	endtask

	// Queued read follows one written byte
	task automatic t_read();
		read_req = 1'b1;
		read_byte = 8'hc3;
		@(negedge clk);
		read_req = 1'b0;
		@(negedge clk);
		chk(8'(read_busy), 8'h01);
		i_rcsp_host_model.set_en(1'b1);
		i_rcsp_host_model.shift(8'h11, 8, 1'b0, rb);
		i_rcsp_host_model.shift(8'h00, 8, 1'b1, rb);
		chk(rb, 8'hc3);
		wait_strobes(4);
		chk(ctrl_reg, 8'h11);
		repeat (6) @(negedge clk);
		chk(8'(taken), 8'h01);
		chk(8'(read_busy), 8'h00);
		i_rcsp_host_model.set_en(1'b0);
		chk(8'(d_oe), 8'h00);
		chk(8'(i_rcsp_host_model.clashes), 8'h00);
	endtask

	task automatic t_sleep();
		sleep_req = 1'b1;
		repeat (6) @(negedge clk);
		chk(8'(awake), 8'h00);
		i_rcsp_host_model.set_en(1'b1);
		repeat (6) @(negedge clk);
		chk(8'(awake), 8'h01);
		sleep_req = 1'b0;
		i_rcsp_host_model.set_en(1'b0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(ctrl_reg, CTRL_RST);
		chk(8'(d_oe), 8'h00);
		t_ignored();
		t_write();
		t_partial();
		@(negedge clk);
		t_read();
		@(negedge clk);
		t_sleep();
		final_report();
	end
endmodule
